// >>> cfg_lock_pkg.sv
package cfg_lock_pkg;
	// byte addresses of the two configuration bytes in the movx space
	localparam logic [15:0] first_cfg_addr = 16'hFB00;
	localparam logic [15:0] second_cfg_addr = 16'hFB01;
	// field positions inside the second configuration byte
	localparam int app_lock_bit = 7;
	localparam int data_lock_bit = 6;
	localparam int odd_hiz_bit = 0;
	// erased-flash reset images of the configuration bytes
	localparam logic [7:0] first_cfg_reset = 8'hFF;
	localparam logic [7:0] second_cfg_reset = 8'hFF;
	// apb register byte offsets
	localparam logic [11:0] reg_cfg_bytes = 12'h000;
	localparam logic [11:0] reg_pwm_ctrl = 12'h004;
	localparam logic [11:0] reg_tool_status = 12'h008;
	// pwm control field position of the runtime odd-channel flag
	localparam int pwm_odd_hiz_pos = 0;

	typedef enum logic [1:0] {
		op_read = 2'h0,
		op_program = 2'h1,
		op_erase = 2'h2,
		op_bank_erase = 2'h3
	} tool_op_t;

	typedef enum logic [1:0] {
		path_writer = 2'h0,
		path_icp = 2'h1,
		path_scan = 2'h2
	} tool_path_t;

	typedef enum logic [1:0] {
		area_app = 2'h0,
		area_data = 2'h1,
		area_cfg = 2'h2
	} tool_area_t;

	typedef struct packed {
		logic valid;
		tool_op_t op;
		tool_path_t path;
		tool_area_t area;
	} tool_req_t;

	typedef struct packed {
		logic valid;
		logic granted;
	} tool_ans_t;
endpackage

// >>> cfg_access_judge.sv
`timescale 1ns/1ns
module cfg_access_judge (
	input wire logic app_lock_in,
	input wire logic data_lock_in,
	input wire cfg_lock_pkg::tool_req_t req_in,
	output logic grant_out
);
	always_comb begin
		grant_out = 1'b0;
		if (app_lock_in && data_lock_in) begin
			grant_out = 1'b1;
		end else if (!app_lock_in && data_lock_in) begin
			// data area stays open except bank erase outside icp; app area and config bytes refuse reads only
			if (req_in.area == cfg_lock_pkg::area_data) begin
				if (req_in.op == cfg_lock_pkg::op_bank_erase) begin
					grant_out = (req_in.path == cfg_lock_pkg::path_icp);
				end else begin
					grant_out = 1'b1;
				end
			end else begin
				grant_out = (req_in.op != cfg_lock_pkg::op_read);
			end
		end else if (!app_lock_in && !data_lock_in) begin
			grant_out = (req_in.op != cfg_lock_pkg::op_read);
		end else begin
			// unsupported pair: fail safe by refusing reads
			grant_out = (req_in.op != cfg_lock_pkg::op_read);
		end
	end
endmodule

// >>> cfg_security_lock.sv
// Operation
// - When the odd-channel drive select or the runtime hi-z flag is one, every odd pwm pin is held in high impedance, else pins follow the port mode registers.
// - After every reset the odd-channel drive select bit is copied into the runtime odd-channel hi-z flag.
// - With both lock bits one, tools may erase, program and read both flash areas.
// - With only the app lock cleared, app flash reads are refused but data flash may be programmed and read.
// - With only the app lock cleared, a bank erase of data flash through the icp port is still accepted.
// - With both lock bits cleared, all external reads of both flash areas are refused.
// - When the app lock bit is zero, external reads of the configuration bytes are refused too.
// - The configuration bytes sit at FB00h and FB01h and running code reads them by movx.
`timescale 1ns/1ns
module cfg_security_lock #(
	parameter int odd_channels = 4
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// configuration bytes as held in flash
	input wire logic [7:0] first_cfg_in,
	input wire logic [7:0] second_cfg_in,
	// per-pin drive enables from the port output mode logic, low = drive
	input wire logic [odd_channels-1:0] odd_pwm_oe_n_in,
	// movx read port of the cpu
	input wire logic movx_rd_in,
	input wire logic [15:0] movx_addr_in,
	output logic [7:0] movx_rdata_out,
	output logic movx_hit_out,
	// external tool request
	input wire cfg_lock_pkg::tool_req_t tool_req_in,
	output cfg_lock_pkg::tool_ans_t tool_ans_out,
	output logic [odd_channels-1:0] odd_pwm_oe_n_out,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	logic [7:0] first_cfg;
	logic [7:0] second_cfg;
	logic load_pending;
	logic odd_channel_hiz_flag;
	logic grant;
	logic [7:0] grant_count;
	logic [7:0] refuse_count;
	logic apb_access;
	logic setup_phase;
	logic force_hiz;
	logic [2:0] apb_sel;

	// one-hot offset decode, shared by the write path, the error flag and the read mux
	function automatic logic [2:0] reg_decode(input logic [11:0] addr);
		logic [2:0] sel;
		sel = 3'b000;
		if (addr == cfg_lock_pkg::reg_cfg_bytes) begin
			sel = 3'b001;
		end else if (addr == cfg_lock_pkg::reg_pwm_ctrl) begin
			sel = 3'b010;
		end else if (addr == cfg_lock_pkg::reg_tool_status) begin
			sel = 3'b100;
		end
		return sel;
	endfunction

	assign apb_sel = reg_decode(paddr);
	assign apb_access = psel && penable;
	assign setup_phase = psel && !penable;

	// configuration bytes are latched on the first edge after any reset ends
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			load_pending <= 1'b1;
			first_cfg <= cfg_lock_pkg::first_cfg_reset;
			second_cfg <= cfg_lock_pkg::second_cfg_reset;
		end else if (load_pending) begin
			load_pending <= 1'b0;
			first_cfg <= first_cfg_in;
			second_cfg <= second_cfg_in;
		end
	end

	// runtime flag reloads from the config bit after every reset; software may change it later
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			odd_channel_hiz_flag <= 1'b1;
		end else if (load_pending) begin
			odd_channel_hiz_flag <= second_cfg_in[cfg_lock_pkg::odd_hiz_bit];
		end else if (apb_access && pwrite && apb_sel[1]) begin
			odd_channel_hiz_flag <= pwdata[cfg_lock_pkg::pwm_odd_hiz_pos];
		end
	end

	// hi-z forced while the config bit is set, regardless of the runtime flag
	assign force_hiz = second_cfg[cfg_lock_pkg::odd_hiz_bit] || odd_channel_hiz_flag || load_pending;

	genvar ch;
	generate
		for (ch = 0; ch < odd_channels; ch++) begin : g_odd_pin
			always_ff @(posedge mclk_in) begin
				if (sys_rst_in) begin
					odd_pwm_oe_n_out[ch] <= 1'b1;
				end else if (force_hiz) begin
					odd_pwm_oe_n_out[ch] <= 1'b1;
				end else begin
					odd_pwm_oe_n_out[ch] <= odd_pwm_oe_n_in[ch];
				end
			end
		end
	endgenerate

	// cpu movx reads of the configuration bytes
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			movx_rdata_out <= 8'h00;
			movx_hit_out <= 1'b0;
		end else begin
			movx_hit_out <= 1'b0;
			movx_rdata_out <= 8'h00;
			if (movx_rd_in && movx_addr_in == cfg_lock_pkg::first_cfg_addr) begin
				movx_hit_out <= 1'b1;
				movx_rdata_out <= first_cfg;
			end else if (movx_rd_in && movx_addr_in == cfg_lock_pkg::second_cfg_addr) begin
				movx_hit_out <= 1'b1;
				movx_rdata_out <= second_cfg;
			end
		end
	end

	cfg_access_judge judge (
		.app_lock_in(second_cfg[cfg_lock_pkg::app_lock_bit]),
		.data_lock_in(second_cfg[cfg_lock_pkg::data_lock_bit]),
		.req_in(tool_req_in),
		.grant_out(grant)
	);

	// tool answers one cycle after the request; nothing granted before the load
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			tool_ans_out <= '0;
		end else begin
			tool_ans_out.valid <= tool_req_in.valid;
			tool_ans_out.granted <= tool_req_in.valid && grant && !load_pending;
		end
	end

	// wrapping counters; requests seen while loading are not counted
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			grant_count <= 8'h00;
			refuse_count <= 8'h00;
		end else begin
			if (tool_req_in.valid && !load_pending) begin
				if (grant) begin
					grant_count <= grant_count + 8'h01;
				end else begin
					refuse_count <= refuse_count + 8'h01;
				end
			end
		end
	end

	// zero wait states: ready is registered from the setup cycle so it stands in the access cycle
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	// unmapped offsets and writes to read-only words answer with an error and change nothing
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			if (apb_sel == 3'b000) begin
				pslverr <= 1'b1;
			end else if (apb_sel[0] || apb_sel[2]) begin
				pslverr <= pwrite;
			end else begin
				pslverr <= 1'b0;
			end
		end else begin
			pslverr <= 1'b0;
		end
	end

	// read data is registered in the setup cycle, so it stands together with ready
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && apb_sel[0]) begin
			prdata <= {16'h0000, second_cfg, first_cfg};
		end else if (setup_phase && apb_sel[1]) begin
			prdata <= {31'h0000_0000, odd_channel_hiz_flag};
		end else if (setup_phase && apb_sel[2]) begin
			prdata <= {15'h0000, load_pending, refuse_count, grant_count};
		end else begin
			prdata <= 32'h0000_0000;
		end
	end
endmodule

// >>> cfg_tool_model.sv
`timescale 1ns/1ns
module cfg_tool_model (
	input wire logic go_in,
	input wire logic [5:0] cmd_in,
	input wire logic [1:0] lock_sel_in,
	input wire logic odd_hiz_in,
	output cfg_lock_pkg::tool_req_t req_out,
	output logic [7:0] cfg_out
);
	// idle fields toggle so a stale command never looks live
	assign req_out = {go_in, go_in ? cmd_in : ~cmd_in};
	// tool never programs the unsupported lock pair
	assign cfg_out = {lock_sel_in == 2'h2 ? 2'h3 : lock_sel_in, 5'h1F, odd_hiz_in};
endmodule

// >>> cfg_security_lock_sva.sv
`timescale 1ns/1ns
module cfg_security_lock_sva #(parameter int odd_channels = 4) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] first_cfg_in,
	input wire logic [7:0] second_cfg_in,
	input wire logic movx_rd_in,
	input wire logic [15:0] movx_addr_in,
	input wire logic [7:0] movx_rdata_out,
	input wire logic movx_hit_out,
	input wire cfg_lock_pkg::tool_req_t tool_req_in,
	input wire cfg_lock_pkg::tool_ans_t tool_ans_out,
	input wire logic [odd_channels-1:0] odd_pwm_oe_n_out
);
	logic up;
	// first edge after release only loads the bytes
	always_ff @(posedge mclk_in) up <= !sys_rst_in;
	wire v = tool_req_in.valid && up;
	wire rd = v && tool_req_in.op == cfg_lock_pkg::op_read;
	wire dat = tool_req_in.area == cfg_lock_pkg::area_data;
	wire a7 = second_cfg_in[7];
	wire d6 = second_cfg_in[6];
	wire g = tool_ans_out.granted;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	a_ans_valid: assert property (tool_req_in.valid |=> tool_ans_out.valid) else $error("no answer");
	a_app_read: assert property (rd && tool_req_in.area == cfg_lock_pkg::area_app && !a7 |=> !g) else $error("app read");
	a_cfg_read: assert property (rd && tool_req_in.area == cfg_lock_pkg::area_cfg && !a7 |=> !g) else $error("cfg read");
	a_data_read: assert property (rd && dat && !d6 |=> !g) else $error("data read");
	a_open_grant: assert property (v && a7 && d6 && tool_req_in.area != cfg_lock_pkg::area_cfg |=> g) else $error("open");
	a_data_open: assert property (v && !a7 && d6 && dat && tool_req_in.op[1] == 1'b0 |=> g) else $error("data");
	a_bank_icp: assert property (v && !a7 && d6 && dat && tool_req_in.op == cfg_lock_pkg::op_bank_erase
		&& tool_req_in.path == cfg_lock_pkg::path_icp |=> g) else $error("bank");
	a_hiz_forced: assert property (up && second_cfg_in[0] |=> &odd_pwm_oe_n_out) else $error("hiz");
	a_movx_data: assert property (up && movx_rd_in && movx_addr_in[15:1] == 15'h7D80 |=> movx_hit_out
		&& movx_rdata_out == ($past(movx_addr_in[0]) ? second_cfg_in : first_cfg_in)) else $error("movx");
endmodule
bind cfg_security_lock cfg_security_lock_sva #(.odd_channels(odd_channels)) u_sva (.*);

// >>> tb.sv
`timescale 1ns/1ns
module tb;
	logic mclk_in = 0, sys_rst_in = 1, go = 0, movx_rd_in = 0, psel = 0, penable = 0, pwrite = 0, odd = 0;
	logic pready, pslverr, hit, er;
	logic [1:0] ls = 3, e2;
	logic [5:0] cmd = 0;
	logic [7:0] c0 = 0, c1, rd8;
	logic [3:0] oe_i = 0, oe_o;
	logic [11:0] paddr = 0;
	logic [15:0] ma = 0;
	logic [31:0] pwdata = 0, prdata, r;
	int errors = 0, n_tests = 0, cyc = 0, seed = 32'h425d810c;
	cfg_lock_pkg::tool_req_t req;
	cfg_lock_pkg::tool_ans_t ans;
	always #2 mclk_in = ~mclk_in;
	cfg_tool_model u_cfg_tool_model (.go_in(go), .cmd_in(cmd), .lock_sel_in(ls), .odd_hiz_in(odd), .req_out(req),
		.cfg_out(c1));
	cfg_security_lock u_cfg_security_lock (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .first_cfg_in(c0),
		.second_cfg_in(c1), .odd_pwm_oe_n_in(oe_i), .movx_rd_in(movx_rd_in), .movx_addr_in(ma),
		.movx_rdata_out(rd8), .movx_hit_out(hit), .tool_req_in(req), .tool_ans_out(ans), .odd_pwm_oe_n_out(oe_o),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	task summarize;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	always @(posedge mclk_in) if (++cyc == 5000) begin
		errors++;
		summarize;
	end
	// answer taken at the rising edge that samples pready high, request released only then
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk_in);
		penable <= 1;
		do @(posedge mclk_in); while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
	endtask
	function logic [1:0] ex(logic [1:0] l, logic [5:0] c);
		case (c[5:4])
			0: return {1'b1, c[1:0] == 1 ? l[0] : l[1]};
			3: return {c[1:0] == 1 && l[0], l[1] || c[3:2] == 1};
			default: return {c[1:0] != 2, 1'b1};
		endcase
	endfunction
	initial begin
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk_in);
			sys_rst_in <= 1; ls <= 2'h3 >> k; odd <= k[0]; c0 <= $random(seed); oe_i <= $random(seed);
			repeat (8) @(posedge mclk_in);
			sys_rst_in <= 0;
			repeat (3) @(posedge mclk_in);
			apb(0, 12'h004, 0);
			chk(r[0], odd);
			apb(0, 12'h000, 0);
			chk(r[15:0], {c1, c0});
			apb(1, 12'h00C, 0);
			chk(er, 1);
			chk(oe_o, odd ? 4'hF : oe_i);
			apb(1, 12'h004, 1);
			@(posedge mclk_in);
			@(negedge mclk_in);
			chk(oe_o, 4'hF);
			for (int a = 0; a < 2; a++) begin
				@(posedge mclk_in);
				movx_rd_in <= 1; ma <= 16'hFB00 + a;
				@(posedge mclk_in);
				movx_rd_in <= 0;
				@(negedge mclk_in);
				chk({hit, rd8}, {1'b1, a ? c1 : c0});
			end
			for (int c = 0; c < 64; c++) if (c[3:2] != 3 && c[1:0] != 3) begin
				@(posedge mclk_in);
				go <= 1; cmd <= c;
				@(posedge mclk_in);
				go <= 0;
				@(negedge mclk_in);
				e2 = ex(ls, c);
				if (e2[1]) chk(ans, {1'b1, e2[0]});
			end
		end
		summarize;
	end
endmodule
